/* File: rtl/ppi_pkg.sv */
// constants for the parallel port with interrupts
package ppi_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;
  localparam int          PORT_W   = 16;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_DOUT     = 12'h000;
  localparam logic [11:0] OFS_DIN      = 12'h004;
  localparam logic [11:0] OFS_DIR      = 12'h008;
  localparam logic [11:0] OFS_PINS     = 12'h00c;
  localparam logic [11:0] OFS_FLAG0    = 12'h010;
  localparam logic [11:0] OFS_FLAG1    = 12'h014;
  localparam logic [11:0] OFS_FPOL     = 12'h018;
  localparam logic [11:0] OFS_IRQCTL   = 12'h01c;
  localparam logic [11:0] OFS_MASKCPU  = 12'h020;
  localparam logic [11:0] OFS_MASKEXT  = 12'h024;
  localparam logic [11:0] OFS_EVSTAT   = 12'h028;
  localparam logic [11:0] OFS_EVMASK   = 12'h02c;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD16   = 16'h0000;
  localparam logic [1:0]  RST_IRQ_POL  = 2'h3;
  localparam logic        RST_EXT_TOTEM = 1'b0;
  localparam int          BIT_POL_CPU  = 0;
  localparam int          BIT_POL_EXT  = 1;
  localparam int          BIT_EXT_TOTEM = 2;

  // ---------------------------------------------------------------
  // write master identity on awuser
  // ---------------------------------------------------------------
  localparam logic [1:0]  MST_CPU      = 2'h0;
  localparam logic [1:0]  MST_DMA      = 2'h1;
  localparam logic [1:0]  MST_PCI      = 2'h2;

  // ---------------------------------------------------------------
  // system hook-up and bus answers
  // ---------------------------------------------------------------
  localparam int          ICU_LINES    = 16;
  localparam int          ICU_SRC_NUM  = 9;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* File: rtl/ppi_top.sv */
// sixteen-pin parallel port with flag interrupts and an axi4-lite slave
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps

module ppi_top #(
  parameter int N_PINS = ppi_pkg::PORT_W
) (
  input  wire logic                       I_REF_CLK,
  input  wire logic                       I_RST_B,
  // axi4-lite slave
  input  wire logic [ppi_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic [1:0]                 I_AWUSER,
  input  wire logic                       I_AWVALID,
  output logic                            O_AWREADY,
  input  wire logic [ppi_pkg::DATA_W-1:0] I_WDATA,
  input  wire logic [3:0]                 I_WSTRB,
  input  wire logic                       I_WVALID,
  output logic                            O_WREADY,
  output logic [1:0]                      O_BRESP,
  output logic                            O_BVALID,
  input  wire logic                       I_BREADY,
  input  wire logic [ppi_pkg::ADDR_W-1:0] I_ARADDR,
  input  wire logic                       I_ARVALID,
  output logic                            O_ARREADY,
  output logic [ppi_pkg::DATA_W-1:0]      O_RDATA,
  output logic [1:0]                      O_RRESP,
  output logic                            O_RVALID,
  input  wire logic                       I_RREADY,
  // port pins
  input  wire logic [N_PINS-1:0]          I_PIN,
  output logic [N_PINS-1:0]               O_PIN,
  output logic [N_PINS-1:0]               O_PIN_OE,
  // system side
  input  wire logic                       I_PCI_EXT_ARB,
  output logic [ppi_pkg::ICU_LINES-1:0]   O_ICU_SRC,
  output logic                            O_CPU_IRQ,
  output logic                            O_PCI_REQ1,
  output logic                            O_PCI_REQ1_OE,
  output logic                            O_IRQ
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  generate
    if (N_PINS != ppi_pkg::PORT_W) begin : g_bad_width
      $error("ppi_top: N_PINS must equal the 16-bit register width");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [N_PINS-1:0] pin_meta_q;
  logic [N_PINS-1:0] pin_sync_q;
  logic [N_PINS-1:0] pin_prev_q;
  logic [2:0]        edge_arm_q; // no false edge while prev is still reset
  logic [N_PINS-1:0] dout_q;
  logic [N_PINS-1:0] din_q;
  logic [N_PINS-1:0] dir_q;
  logic [N_PINS-1:0] flag_q;
  logic [N_PINS-1:0] fpol_q;
  logic [N_PINS-1:0] mask_cpu_q;
  logic [N_PINS-1:0] mask_ext_q;
  logic [N_PINS-1:0] ev_stat_q;
  logic [N_PINS-1:0] ev_mask_q;
  logic [1:0]        irq_pol_q;
  logic              ext_totem_q;
  logic              cpu_req_q;
  logic              ext_req_q;

  logic                      aw_full_q;
  logic [ppi_pkg::ADDR_W-1:0] aw_addr_q;
  logic [1:0]                aw_user_q;
  logic                      w_full_q;
  logic [ppi_pkg::DATA_W-1:0] w_data_q;
  logic [3:0]                w_strb_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      rvalid_q;
  logic [1:0]                rresp_q;
  logic [ppi_pkg::DATA_W-1:0] rdata_q;

  // ---------------------------------------------------------------
  // pin synchroniser and capture
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_meta_q <= ppi_pkg::RST_WORD16;
      pin_sync_q <= ppi_pkg::RST_WORD16;
      pin_prev_q <= ppi_pkg::RST_WORD16;
      edge_arm_q <= '0;
    end else begin
      pin_meta_q <= I_PIN;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      edge_arm_q <= {edge_arm_q[1:0], 1'b1};
    end
  end

  // input data follows a pin only while it is an input
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_din
      always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          din_q[gi] <= 1'b0;
        end else if (!dir_q[gi]) begin
          din_q[gi] <= pin_sync_q[gi];
        end
      end
    end
  endgenerate

  assign O_PIN    = dout_q;
  assign O_PIN_OE = dir_q;

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  logic              wr_go;
  logic [15:0]       wr_mask;
  logic [15:0]       wr_data;
  logic              wr_hit;
  logic [11:0]       wr_ofs;

  assign O_AWREADY = !aw_full_q && !bvalid_q;
  assign O_WREADY  = !w_full_q && !bvalid_q;
  assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ofs    = aw_addr_q & ~12'h003;
  // only the two low byte lanes carry register bits
  assign wr_mask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_data   = w_data_q[15:0] & wr_mask;

  always_comb begin
    unique case (wr_ofs)
      ppi_pkg::OFS_DOUT, ppi_pkg::OFS_DIR, ppi_pkg::OFS_FLAG0,
      ppi_pkg::OFS_FLAG1, ppi_pkg::OFS_FPOL, ppi_pkg::OFS_IRQCTL,
      ppi_pkg::OFS_MASKCPU, ppi_pkg::OFS_MASKEXT,
      ppi_pkg::OFS_EVSTAT, ppi_pkg::OFS_EVMASK,
      ppi_pkg::OFS_DIN, ppi_pkg::OFS_PINS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      aw_user_q <= ppi_pkg::MST_CPU;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= I_AWADDR;
      aw_user_q <= I_AWUSER;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (I_WVALID && O_WREADY) begin
      w_full_q <= 1'b1;
      w_data_q <= I_WDATA;
      w_strb_q <= I_WSTRB;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ppi_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign O_BVALID = bvalid_q;
  assign O_BRESP  = bresp_q;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old_v);
    merge = (old_v & ~wr_mask) | wr_data;
  endfunction

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      dout_q     <= ppi_pkg::RST_WORD16;
      dir_q      <= ppi_pkg::RST_WORD16;
      fpol_q     <= ppi_pkg::RST_WORD16;
      mask_cpu_q <= ppi_pkg::RST_WORD16;
      mask_ext_q <= ppi_pkg::RST_WORD16;
      ev_mask_q  <= ppi_pkg::RST_WORD16;
      irq_pol_q  <= ppi_pkg::RST_IRQ_POL;
      ext_totem_q <= ppi_pkg::RST_EXT_TOTEM;
    end else if (wr_go) begin
      unique case (wr_ofs)
        ppi_pkg::OFS_DOUT:    dout_q     <= merge(dout_q);
        ppi_pkg::OFS_DIR:     dir_q      <= merge(dir_q);
        ppi_pkg::OFS_FPOL:    fpol_q     <= merge(fpol_q);
        ppi_pkg::OFS_MASKCPU: mask_cpu_q <= merge(mask_cpu_q);
        ppi_pkg::OFS_MASKEXT: mask_ext_q <= merge(mask_ext_q);
        ppi_pkg::OFS_EVMASK:  ev_mask_q  <= merge(ev_mask_q);
        ppi_pkg::OFS_IRQCTL: begin
          if (w_strb_q[0]) begin
            irq_pol_q   <= w_data_q[ppi_pkg::BIT_POL_EXT:
                                    ppi_pkg::BIT_POL_CPU];
            ext_totem_q <= w_data_q[ppi_pkg::BIT_EXT_TOTEM];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event flags, two aliases over one store
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      flag_q <= ppi_pkg::RST_WORD16;
    end else if (wr_go && wr_ofs == ppi_pkg::OFS_FLAG0) begin
      flag_q <= merge(flag_q);
    end else if (wr_go && wr_ofs == ppi_pkg::OFS_FLAG1) begin
      if (aw_user_q == ppi_pkg::MST_CPU) begin
        flag_q <= flag_q | wr_data;
      end else if (aw_user_q == ppi_pkg::MST_DMA ||
                   aw_user_q == ppi_pkg::MST_PCI) begin
        flag_q <= flag_q & ~wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin change events: sticky, write one to clear
  // ---------------------------------------------------------------
  logic [15:0] ev_clr;
  logic [15:0] ev_set;

  assign ev_clr = (wr_go && wr_ofs == ppi_pkg::OFS_EVSTAT) ? wr_data : '0;
  assign ev_set = (pin_sync_q ^ pin_prev_q) & {N_PINS{edge_arm_q[2]}};

  // a change landing in the clearing cycle stays set
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ev_stat_q <= ppi_pkg::RST_WORD16;
    end else begin
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end
  end

  assign O_IRQ = |(ev_stat_q & ev_mask_q);

  // ---------------------------------------------------------------
  // request outputs
  // ---------------------------------------------------------------
  logic [15:0] flag_act;
  logic        cpu_req_d;
  logic        ext_req_d;

  assign flag_act  = flag_q ^ fpol_q;
  assign cpu_req_d = |(flag_act & mask_cpu_q) ^
                     irq_pol_q[ppi_pkg::BIT_POL_CPU];
  assign ext_req_d = |(flag_act & mask_ext_q) ^
                     irq_pol_q[ppi_pkg::BIT_POL_EXT];

  // registered so both read one straight out of reset
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cpu_req_q <= 1'b1;
      ext_req_q <= 1'b1;
    end else begin
      cpu_req_q <= cpu_req_d;
      ext_req_q <= ext_req_d;
    end
  end

  assign O_CPU_IRQ = cpu_req_q;

  always_comb begin
    O_ICU_SRC = '0;
    O_ICU_SRC[ppi_pkg::ICU_SRC_NUM] = cpu_req_q;
  end

  // open drain only pulls low; outside arbiter mode the pin is released
  assign O_PCI_REQ1    = ext_req_q;
  assign O_PCI_REQ1_OE = I_PCI_EXT_ARB &&
                         (ext_totem_q || !ext_req_q);

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  logic [ppi_pkg::DATA_W-1:0] rd_val;
  logic                      rd_hit;
  logic [11:0]               rd_ofs;

  assign rd_ofs    = I_ARADDR & ~12'h003;
  assign O_ARREADY = !rvalid_q;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (rd_ofs)
      ppi_pkg::OFS_DOUT:    rd_val[15:0] = dout_q;
      ppi_pkg::OFS_DIN:     rd_val[15:0] = din_q;
      ppi_pkg::OFS_DIR:     rd_val[15:0] = dir_q;
      ppi_pkg::OFS_PINS:    rd_val[15:0] = pin_sync_q;
      ppi_pkg::OFS_FLAG0,
      ppi_pkg::OFS_FLAG1:   rd_val[15:0] = flag_q;
      ppi_pkg::OFS_FPOL:    rd_val[15:0] = fpol_q;
      ppi_pkg::OFS_IRQCTL: begin
        rd_val[ppi_pkg::BIT_POL_EXT:ppi_pkg::BIT_POL_CPU] = irq_pol_q;
        rd_val[ppi_pkg::BIT_EXT_TOTEM] = ext_totem_q;
      end
      ppi_pkg::OFS_MASKCPU: rd_val[15:0] = mask_cpu_q;
      ppi_pkg::OFS_MASKEXT: rd_val[15:0] = mask_ext_q;
      ppi_pkg::OFS_EVSTAT:  rd_val[15:0] = ev_stat_q;
      ppi_pkg::OFS_EVMASK:  rd_val[15:0] = ev_mask_q;
      default:              rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rvalid_q <= 1'b0;
      rresp_q  <= ppi_pkg::RESP_OKAY;
      rdata_q  <= '0;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
      rdata_q  <= rd_val;
    end else if (I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign O_RVALID = rvalid_q;
  assign O_RRESP  = rresp_q;
  assign O_RDATA  = rdata_q;

endmodule

/* File: testbench/ppi_sva.sv */
// checker for the parallel port with interrupts
`timescale 1ns/1ps

module ppi_sva (
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_PCI_EXT_ARB,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic [15:0] O_ICU_SRC,
  input wire logic [15:0] O_PIN,
  input wire logic [15:0] O_PIN_OE,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_CPU_IRQ,
  input wire logic        O_PCI_REQ1,
  input wire logic        O_PCI_REQ1_OE,
  input wire logic        O_BVALID,
  input wire logic        O_RVALID,
  input wire logic        O_ARREADY
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  property p_src9; O_ICU_SRC == {6'h0, O_CPU_IRQ, 9'h0}; endproperty
  property p_rst_req; $rose(I_RST_B) |-> O_CPU_IRQ && O_PCI_REQ1; endproperty
  property p_ext_off; !I_PCI_EXT_ARB |-> !O_PCI_REQ1_OE; endproperty
  // pin registers only move on the edge that completes a write
  property p_dir; $changed(O_PIN_OE) |-> $rose(O_BVALID); endproperty
  property p_dout; $changed(O_PIN) |-> $rose(O_BVALID); endproperty
  property p_cpu; $changed(O_CPU_IRQ) |-> $past(O_BVALID); endproperty
  property p_ext; $changed(O_PCI_REQ1) |-> $past(O_BVALID); endproperty
  property p_bhold; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
  property p_rhold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  property p_ar; O_RVALID |-> !O_ARREADY; endproperty

  a_src9:    assert property (p_src9) else $error("icu line wrong");
  a_rst_req: assert property (p_rst_req) else $error("reset req");
  a_ext_off: assert property (p_ext_off) else $error("req1 driven");
  a_dir:     assert property (p_dir) else $error("dir moved");
  a_dout:    assert property (p_dout) else $error("dout moved");
  a_cpu:     assert property (p_cpu) else $error("cpu req moved");
  a_ext:     assert property (p_ext) else $error("ext req moved");
  a_bhold:   assert property (p_bhold) else $error("bvalid dropped");
  a_rhold:   assert property (p_rhold) else $error("rdata unstable");
  a_ar:      assert property (p_ar) else $error("ar taken early");

  c_cpu: cover property ($rose(O_CPU_IRQ));
  c_oe:  cover property ($fell(O_PCI_REQ1_OE));
  c_rd:  cover property (O_RVALID && I_RREADY);
endmodule

bind ppi_top ppi_sva u_ppi_sva (.I_REF_CLK, .I_RST_B, .I_PCI_EXT_ARB,
  .I_BREADY, .I_RREADY, .O_ICU_SRC, .O_PIN, .O_PIN_OE, .O_RDATA,
  .O_CPU_IRQ, .O_PCI_REQ1, .O_PCI_REQ1_OE, .O_BVALID, .O_RVALID,
  .O_ARREADY);

/* File: testbench/ppi_pins.sv */
// outside world on the sixteen port pins
`timescale 1ns/1ps

module ppi_pins (
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  input  wire logic [15:0] i_ext,
  output logic      [15:0] o_level
);
  // a pin the port does not drive follows the outside source
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule

/* File: testbench/tb_parallel_port_with_interrupts.sv */
// self-checking bench for the parallel port with interrupts
`timescale 1ns/1ps

module tb_parallel_port_with_interrupts;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [1:0]  awuser = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, arb = 1'h0;
  logic [15:0] ext = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cpu, req, req_oe, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pin_o, pin_oe, icu, lvl;
  logic [15:0] m_flag = 16'h0, m_pol = 16'h0, m_mc = 16'h0, m_me = 16'h0;
  logic [15:0] m_dir = 16'h0, m_dout = 16'h0;
  logic [2:0]  m_ctl = 3'h3;
  int          err_total = 0;
  int          tests_run = 0;

  always #4 clk = ~clk;

  ppi_top u_ppi_top (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr),
    .I_AWUSER(awuser), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .I_PIN(lvl), .O_PIN(pin_o),
    .O_PIN_OE(pin_oe), .I_PCI_EXT_ARB(arb), .O_ICU_SRC(icu),
    .O_CPU_IRQ(cpu), .O_PCI_REQ1(req), .O_PCI_REQ1_OE(req_oe),
    .O_IRQ(irq)
  );

  ppi_pins u_ppi_pins (
    .i_pin_out(pin_o), .i_pin_oe(pin_oe), .i_ext(ext), .o_level(lvl)
  );

  // ---------------------------------------------------------------
  // compare, bus and model tasks
  // ---------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t port got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("counts tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // address and data go out together; each is dropped once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] u = ppi_pkg::MST_CPU,
                    input logic [1:0] er = ppi_pkg::RESP_OKAY);
    bit db;
    db = 0;
    @(posedge clk);
    awaddr <= a;
    awuser <= u;
    wdata <= {16'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!db) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        db = 1;
        bready <= 1'h0;
        chk_reg({30'h0, bresp}, {30'h0, er});
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_reg(d, e);
    chk_reg({30'h0, r}, {30'h0, ppi_pkg::RESP_OKAY});
  endtask

  task automatic put(input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] u = ppi_pkg::MST_CPU);
    wr(a, d, u);
    case (a)
      ppi_pkg::OFS_DOUT:    m_dout = d;
      ppi_pkg::OFS_DIR:     m_dir = d;
      ppi_pkg::OFS_FLAG0:   m_flag = d;
      ppi_pkg::OFS_FLAG1:   m_flag = (u == ppi_pkg::MST_CPU) ?
                                     (m_flag | d) : (m_flag & ~d);
      ppi_pkg::OFS_FPOL:    m_pol = d;
      ppi_pkg::OFS_IRQCTL:  m_ctl = d[2:0];
      ppi_pkg::OFS_MASKCPU: m_mc = d;
      ppi_pkg::OFS_MASKEXT: m_me = d;
      default: ;
    endcase
  endtask

  function automatic logic f_req(input logic [15:0] m, input logic p);
    return |((m_flag ^ m_pol) & m) ^ p;
  endfunction

  task automatic chk_req;
    logic c, e;
    c = f_req(m_mc, m_ctl[0]);
    e = f_req(m_me, m_ctl[1]);
    @(negedge clk);
    chk_pin({15'h0, cpu}, {15'h0, c});
    chk_pin(icu, {6'h0, c, 9'h0});
    chk_pin({15'h0, req}, {15'h0, e});
    chk_pin({15'h0, req_oe}, {15'h0, arb & (m_ctl[2] | !e)});
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] v;
    void'($urandom(79309));
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    chk_pin({14'h0, cpu, req}, 16'h0003);
    rdc(ppi_pkg::OFS_MASKCPU, 32'h0);
    rdc(ppi_pkg::OFS_MASKEXT, 32'h0);
    rdc(ppi_pkg::OFS_IRQCTL, 32'h3);
    rdc(ppi_pkg::OFS_FPOL, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      put(ppi_pkg::OFS_FLAG0, 16'($urandom));
      rdc(ppi_pkg::OFS_FLAG0, {16'h0, m_flag});
      rdc(ppi_pkg::OFS_FLAG1, {16'h0, m_flag});
      put(ppi_pkg::OFS_FLAG1, 16'($urandom), 2'(i));
      rdc(ppi_pkg::OFS_FLAG0, {16'h0, m_flag});
    end
    $display("test flag aliases done");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      arb <= 1'($urandom);
      put(ppi_pkg::OFS_FPOL, 16'($urandom));
      put(ppi_pkg::OFS_MASKCPU, (i < 2) ? 16'h0 : 16'($urandom));
      put(ppi_pkg::OFS_MASKEXT, (i < 2) ? 16'h0 : 16'($urandom));
      put(ppi_pkg::OFS_IRQCTL, 16'($urandom) & 16'h0007);
      put(ppi_pkg::OFS_FLAG0, 16'($urandom));
      chk_req;
    end
    $display("test request formula done");
    for (int i = 0; i < 4; i++) begin
      put(ppi_pkg::OFS_DIR, 16'($urandom));
      put(ppi_pkg::OFS_DOUT, 16'($urandom));
      @(posedge clk);
      ext <= 16'($urandom);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk_pin(pin_oe, m_dir);
      chk_pin(pin_o & m_dir, m_dout & m_dir);
      v = (m_dir & m_dout) | (~m_dir & ext);
      rdc(ppi_pkg::OFS_PINS, {16'h0, v});
      rd(ppi_pkg::OFS_DIN, d, r);
      chk_reg(d & {16'h0, ~m_dir}, {16'h0, ext & ~m_dir});
    end
    $display("test pins done");
    put(ppi_pkg::OFS_DIR, 16'h0);
    repeat (4) @(posedge clk);
    wr(ppi_pkg::OFS_EVSTAT, 16'hffff);
    wr(ppi_pkg::OFS_EVMASK, 16'hffff);
    @(negedge clk);
    chk_pin({15'h0, irq}, 16'h0);
    v = 16'($urandom) | 16'h0001;
    @(posedge clk);
    ext <= ext ^ v;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_pin({15'h0, irq}, 16'h0001);
    rdc(ppi_pkg::OFS_EVSTAT, {16'h0, v});
    wr(ppi_pkg::OFS_EVMASK, 16'h0);
    @(negedge clk);
    chk_pin({15'h0, irq}, 16'h0);
    wr(ppi_pkg::OFS_EVSTAT, 16'hffff);
    rdc(ppi_pkg::OFS_EVSTAT, 32'h0);
    wr(12'h030, 16'h1234, ppi_pkg::MST_CPU, ppi_pkg::RESP_SLVERR);
    rd(12'h030, d, r);
    chk_reg(d, 32'h0);
    chk_reg({30'h0, r}, {30'h0, ppi_pkg::RESP_SLVERR});
    $display("test events and unmapped done");
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    chk_pin({14'h0, cpu, req}, 16'h0003);
    rdc(ppi_pkg::OFS_IRQCTL, 32'h3);
    rdc(ppi_pkg::OFS_EVSTAT, 32'h0);
    $display("test second reset done");
    conclude;
  end
endmodule
